// ==== rtl/drive_security_lock_commands.v ====
`timescale 1ns/1ps
`include "sec_lock_regs.vh"
module drive_security_lock_commands (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        nv_clear,
    // link reset pins, asynchronous
    input  wire        comreset_pin,
    input  wire        ssp_disable_pin,
    // command register write
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_code,
    // host-to-device sector data
    input  wire        data_valid,
    input  wire [15:0] data_word,
    // task file answer
    output reg  [7:0]  command_status_flags,
    output reg  [7:0]  command_error_flags,
    output reg         cmd_done_reg,
    // security state
    output reg         frozen_reg,
    output reg         locked_reg,
    output reg         lock_enabled_reg,
    output reg         level_max_reg,
    output reg  [15:0] identify_w92_reg,
    output reg         user_match_reg,
    output reg         master_unlock_ok_reg,
    output reg         erase_only_reg
);
    // one-hot command states
    localparam [2:0] ST_IDLE  = 3'h1;   // waiting for a command
    localparam [2:0] ST_XFER  = 3'h2;   // taking the password sector
    localparam [2:0] ST_APPLY = 3'h4;   // commit the captured sector

    reg  [2:0]           state_reg;      // command sequencer
    reg  [2:0]           state_next;
    reg  [8:0]           word_cnt_reg;   // words taken in this sector
    reg                  ident_reg;      // 1 selects the master password
    reg                  level_reg;      // 1 selects maximum level
    reg  [`PWD_BITS-1:0] pwd_buf_reg;    // password words 1..16
    reg  [15:0]          rev_lo_reg;     // revision code from word 17
    reg  [15:0]          rev_hi_reg;     // word 18, kept with it
    reg                  comreset_d_reg; // for edge detect
    wire [1:0]           link_sync;      // synchronised link pins
    wire                 comreset_rise;  // link reset seen
    wire                 user_match;
    wire                 master_match;
    wire                 is_security;    // any security opcode except freeze-lock
    wire                 word_take;      // a sector word accepted
    wire [7:0]           word_idx;

    // link pins come from outside the clock domain
    level_sync #(
        .WIDTH    (2)
    ) u_link_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({ssp_disable_pin, comreset_pin}),
        .sync_out (link_sync)
    );

    // user and master passwords, each loaded from the sector buffer
    password_slot u_user_slot (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .nv_clear  (nv_clear),
        .load      (state_reg == ST_APPLY && !ident_reg),
        .candidate (pwd_buf_reg),
        .match     (user_match)
    );

    password_slot u_master_slot (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .nv_clear  (nv_clear),
        .load      (state_reg == ST_APPLY && ident_reg),
        .candidate (pwd_buf_reg),
        .match     (master_match)
    );

    // only the opcode is looked at; other task file registers never
    // reach this block
    assign is_security = (cmd_code == `CMD_SET_PASSWORD)  ||
                         (cmd_code == `CMD_UNLOCK)        ||
                         (cmd_code == `CMD_ERASE_PREPARE) ||
                         (cmd_code == `CMD_ERASE_UNIT)    ||
                         (cmd_code == `CMD_DISABLE_PWD);

    assign comreset_rise = link_sync[0] && !comreset_d_reg;
    assign word_take     = (state_reg == ST_XFER) && data_valid;
    assign word_idx      = word_cnt_reg[7:0];

    // sequencer next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // set-password opens the one-sector transfer
                if (cmd_valid && cmd_code == `CMD_SET_PASSWORD &&
                    !frozen_reg) begin
                    state_next = ST_XFER;
                end
            end
            ST_XFER: begin
                // exactly 256 words, then act on them
                if (word_take && word_cnt_reg == `SECTOR_WORDS - 9'h001) begin
                    state_next = ST_APPLY;
                end
            end
            ST_APPLY: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state register and link reset edge memory
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            comreset_d_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            comreset_d_reg <= link_sync[0];
        end
    end

    // sector capture: word counter, control word, password, revision
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            word_cnt_reg <= 9'h000;
            ident_reg    <= 1'b0;
            level_reg    <= 1'b0;
            pwd_buf_reg  <= {`PWD_BITS{1'b0}};
            rev_lo_reg   <= 16'h0000;
            rev_hi_reg   <= 16'h0000;
        end else if (state_reg == ST_IDLE) begin
            // restart the count for the next sector
            word_cnt_reg <= 9'h000;
        end else if (word_take) begin
            word_cnt_reg <= word_cnt_reg + 9'h001;
            if (word_cnt_reg == 9'h000) begin
                // reserved bits of the control word are dropped
                ident_reg <= data_word[`CW_IDENT_BIT];
                level_reg <= data_word[`CW_LEVEL_BIT];
            end else if (word_idx >= `PWD_FIRST_WORD &&
                         word_idx <= `PWD_LAST_WORD &&
                         !word_cnt_reg[8]) begin
                // shift in so word 1 ends up in the low bits
                pwd_buf_reg <= {data_word,
                                pwd_buf_reg[`PWD_BITS-1:16]};
            end else if (word_idx == `REV_LO_WORD && !word_cnt_reg[8]) begin
                rev_lo_reg <= data_word;
            end else if (word_idx == `REV_HI_WORD && !word_cnt_reg[8]) begin
                rev_hi_reg <= data_word;
            end
            // words 19..255 are reserved and only counted
        end
    end

    // frozen mode: set by freeze-lock, cleared only by power-on reset;
    // a link reset does not touch it
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            frozen_reg <= 1'b0;
        end else if (cmd_valid && state_reg == ST_IDLE &&
                     cmd_code == `CMD_FREEZE_LOCK) begin
            frozen_reg <= 1'b1;
        end
    end

    // persistent security settings, kept across power-on reset unless nv_clear is set
    always @(posedge ref_clk) begin
        if (!rst_n && nv_clear) begin
            lock_enabled_reg <= 1'b0;
            level_max_reg    <= 1'b0;
            identify_w92_reg <= `REV_DEFAULT;
        end else if (rst_n && state_reg == ST_APPLY) begin
            if (ident_reg) begin
                // master: store only, the lock feature is left alone
                if (rev_lo_reg != `REV_BAD_LOW &&
                    rev_lo_reg != `REV_BAD_HIGH) begin
                    identify_w92_reg <= rev_lo_reg;
                end
            end else begin
                // user: arm the lock at the chosen level
                lock_enabled_reg <= 1'b1;
                level_max_reg    <= level_reg;
            end
        end
    end

    // lock takes effect at power-on or link reset without preservation;
    // arming never locks immediately
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            locked_reg <= lock_enabled_reg;
        end else if (comreset_rise && link_sync[1]) begin
            locked_reg <= lock_enabled_reg;
        end
    end

    // unlock qualifiers for the unlock and erase paths
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            user_match_reg       <= 1'b0;
            master_unlock_ok_reg <= 1'b0;
            erase_only_reg       <= 1'b0;
        end else begin
            user_match_reg       <= user_match;
            // master opens the lock only at high level
            master_unlock_ok_reg <= master_match &&
                                    !level_max_reg;
            // maximum level without the user password: erase is the way
            erase_only_reg       <= lock_enabled_reg && level_max_reg &&
                                    !user_match;
        end
    end

    // task file answer: drq during the sector, busy once it is complete, abort on reject
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            command_status_flags <= `STS_RESET;
            command_error_flags  <= `ERR_RESET;
            cmd_done_reg         <= 1'b0;
        end else begin
            cmd_done_reg <= 1'b0;
            if (state_reg == ST_IDLE && cmd_valid &&
                cmd_code == `CMD_FREEZE_LOCK) begin
                // completes at once, no data phase
                command_status_flags <= `STS_RESET;
                command_error_flags  <= `ERR_RESET;
                cmd_done_reg         <= 1'b1;
            end else if (state_reg == ST_IDLE && cmd_valid && is_security &&
                         (frozen_reg ||
                          cmd_code != `CMD_SET_PASSWORD)) begin
                // rejected: error plus abort, ready kept set, every other bit clear
                command_status_flags <= `STS_RESET |
                                        (8'h01 << `STS_ERR_BIT);
                command_error_flags  <= 8'h01 << `ERR_ABORT_BIT;
                cmd_done_reg         <= 1'b1;
            end else if (state_next == ST_XFER) begin
                // ready for the sector
                command_status_flags <= `STS_RESET |
                                        (8'h01 << `STS_DRQ_BIT);
                command_error_flags  <= `ERR_RESET;
            end else if (state_next == ST_APPLY) begin
                // sector complete, drive busy while it commits
                command_status_flags <= 8'h01 << `STS_BUSY_BIT;
            end else if (state_reg == ST_APPLY) begin
                command_status_flags <= `STS_RESET;
                command_error_flags  <= `ERR_RESET;
                cmd_done_reg         <= 1'b1;
            end
        end
    end
endmodule // drive_security_lock_commands

// ==== rtl/sec_lock_regs.vh ====
`ifndef SEC_LOCK_REGS_VH
`define SEC_LOCK_REGS_VH

// command codes decoded from the command register
`define CMD_SET_PASSWORD    8'hF1
`define CMD_UNLOCK          8'hF2
`define CMD_ERASE_PREPARE   8'hF3
`define CMD_ERASE_UNIT      8'hF4
`define CMD_FREEZE_LOCK     8'hF5
`define CMD_DISABLE_PWD     8'hF6

// status register bit positions
`define STS_BUSY_BIT        7
`define STS_READY_BIT       6
`define STS_DRQ_BIT         3
`define STS_ERR_BIT         0
`define STS_RESET           8'h40

// error register bit positions
`define ERR_ABORT_BIT       2
`define ERR_RESET           8'h00

// control word 0 field positions
`define CW_IDENT_BIT        0
`define CW_LEVEL_BIT        8

// sector layout, in 16-bit words
`define SECTOR_WORDS        9'h100
`define PWD_FIRST_WORD      8'h01
`define PWD_LAST_WORD       8'h10
`define REV_LO_WORD         8'h11
`define REV_HI_WORD         8'h12
`define PWD_BITS            256

// master revision code values
`define REV_DEFAULT         16'hFFFE
`define REV_BAD_LOW         16'h0000
`define REV_BAD_HIGH        16'hFFFF

`endif

// ==== rtl/level_sync.v ====
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pin levels
module level_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // asynchronous levels in, synchronised levels out
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;   // first stage, read only by second stage

    // first stage feeds only the second stage
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // level_sync

// ==== rtl/password_slot.v ====
`timescale 1ns/1ps
`include "sec_lock_regs.vh"
// one stored password with a full-width comparator
module password_slot (
    // clock and reset
    input  wire                  ref_clk,
    input  wire                  rst_n,
    input  wire                  nv_clear,
    // load and compare
    input  wire                  load,
    input  wire [`PWD_BITS-1:0]  candidate,
    output wire                  match
);
    reg [`PWD_BITS-1:0] value_reg;  // stored password text

    // contents survive power-on reset unless the store is being cleared
    always @(posedge ref_clk) begin
        if (!rst_n && nv_clear) begin
            value_reg <= {`PWD_BITS{1'b0}};
        end else if (rst_n && load) begin
            value_reg <= candidate;
        end
    end

    // all 32 bytes take part; nothing is treated as padding
    assign match = (value_reg == candidate);
endmodule // password_slot

// ==== verification/lock_cmd_host_model.sv ====
`timescale 1ns/1ps
// host side: writes the command register and feeds one sector
module host_model (
    // clock
    input  wire        ref_clk,
    // toward the device
    output reg         cmd_valid,
    output reg  [7:0]  cmd_code,
    output reg         data_valid,
    output reg  [15:0] data_word
);
    // idle at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        data_valid = 1'b0;
        data_word = 16'h0000;
    end
    // one-cycle write; code inverted once released so stale values show
    task issue(input [7:0] code);
        @(posedge ref_clk) #1;
        cmd_valid = 1'b1;
        cmd_code = code;
        @(posedge ref_clk) #1;
        cmd_valid = 1'b0;
        cmd_code = ~code;
    endtask
    // all 256 words back to back: control, password p+k, revision code
    task sector(input [15:0] ctrl, input [15:0] p, input [15:0] rev);
        integer k;
        for (k = 0; k < 256; k = k + 1) begin
            @(posedge ref_clk) #1;
            data_valid = 1'b1;
            data_word = k == 0 ? ctrl : k == 17 ? rev : p + k[15:0];
        end
        @(posedge ref_clk) #1;
        data_valid = 1'b0;
        data_word = ~data_word;
    endtask
endmodule // host_model

// ==== verification/drive_security_lock_commands_checker.sv ====
`timescale 1ns/1ps
// watches answers and security state at the lock block's ports
module lock_cmd_checker (
    // clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    // command register write
    input wire        cmd_valid,
    input wire [7:0]  cmd_code,
    // answer and state
    input wire [7:0]  command_status_flags,
    input wire [7:0]  command_error_flags,
    input wire        cmd_done_reg,
    input wire        frozen_reg,
    input wire        lock_enabled_reg,
    input wire [15:0] identify_w92_reg
);
    // writes count only outside the sector phase
    wire       idle = ~command_status_flags[3] & ~command_status_flags[7];
    wire       take = cmd_valid & idle;
    wire [7:0] sts = command_status_flags;
    // opcodes never carried out here
    wire       nogo = cmd_code == 8'hF2 || cmd_code == 8'hF3 ||
                      cmd_code == 8'hF4 || cmd_code == 8'hF6;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_freeze_enter: assert property (
        take && cmd_code == 8'hF5 |=> frozen_reg && cmd_done_reg)
        else $error("freeze lock not completed");
    a_frozen_held: assert property (frozen_reg |=> frozen_reg)
        else $error("frozen mode left");
    a_frozen_reject: assert property (
        take && frozen_reg && cmd_code == 8'hF1 |=> sts == 8'h41)
        else $error("set password accepted while frozen");
    a_reject_flags: assert property (
        take && nogo |=> sts == 8'h41 && command_error_flags == 8'h04)
        else $error("reject flags wrong");
    a_set_drq: assert property (
        take && !frozen_reg && cmd_code == 8'hF1 |=> sts == 8'h48)
        else $error("no data request after set password");
    a_error_pairs: assert property (
        cmd_done_reg |-> command_error_flags == {5'h00, sts[0], 2'h0})
        else $error("error flags disagree with status");
    a_lock_rise: assert property (
        $rose(lock_enabled_reg) |-> cmd_done_reg && sts == 8'h40)
        else $error("lock enabled outside set password");
    a_rev_valid: assert property (
        identify_w92_reg != 16'h0000 && identify_w92_reg != 16'hFFFF)
        else $error("revision code out of range");
    c_freeze: cover property (take && cmd_code == 8'hF5);
    c_set: cover property (sts == 8'h80 ##1 cmd_done_reg);
    c_reject: cover property (take && nogo ##1 cmd_done_reg);
endmodule // lock_cmd_checker
bind drive_security_lock_commands lock_cmd_checker i_lock_cmd_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .command_status_flags(command_status_flags),
    .command_error_flags(command_error_flags), .cmd_done_reg(cmd_done_reg),
    .frozen_reg(frozen_reg), .lock_enabled_reg(lock_enabled_reg),
    .identify_w92_reg(identify_w92_reg));

// ==== verification/drive_security_lock_commands_tb_top.sv ====
`timescale 1ns/1ps
// bench top: host model issues commands, scenario tasks judge answers
module drive_security_lock_commands_tb_top;
    // driven here
    reg         ref_clk, rst_n, nv_clear, comreset_pin, ssp_disable_pin;
    wire        cmd_valid, data_valid, done, frozen, locked, lock_en, lvl_max;
    wire        user_ok, master_ok, erase_only;
    wire [7:0]  cmd_code, sts, err;
    wire [15:0] data_word, w92;
    integer     mismatches, samples_checked, i;
    host_model i_host_model (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .data_valid(data_valid), .data_word(data_word));
    drive_security_lock_commands i_drive_security_lock_commands (
        .ref_clk(ref_clk), .rst_n(rst_n), .nv_clear(nv_clear),
        .comreset_pin(comreset_pin), .ssp_disable_pin(ssp_disable_pin),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .data_valid(data_valid),
        .data_word(data_word), .command_status_flags(sts),
        .command_error_flags(err), .cmd_done_reg(done), .frozen_reg(frozen),
        .locked_reg(locked), .lock_enabled_reg(lock_en),
        .level_max_reg(lvl_max), .identify_w92_reg(w92),
        .user_match_reg(user_ok), .master_unlock_ok_reg(master_ok),
        .erase_only_reg(erase_only));
    // 50 MHz
    always #10 ref_clk = ~ref_clk;
    // compare, report and count a difference
    task check(input [15:0] got, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // bounded wait; completion must come exactly want cycles later
    task wait_done(input [15:0] want);
        integer n;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge ref_clk) #1;
            n = n + 1;
        end
        if (n == 400) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t no completion", $time);
            tally_and_finish;
        end else
            check(n, want);
    endtask
    // power cycle, persistent store wiped only when nv is set
    task power_on(input nv);
        @(posedge ref_clk) #1;
        rst_n = 1'b0;
        nv_clear = nv;
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        nv_clear = 1'b0;
    endtask
    // link reset pulse; pins are async, so allow the synchroniser delay
    task link_reset(input ssp);
        ssp_disable_pin = ssp;
        repeat (4) @(posedge ref_clk);
        #1 comreset_pin = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 comreset_pin = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask
    // done is already up when the one-cycle write has been released
    task cmd(input [7:0] code);
        i_host_model.issue(code);
        wait_done(0);
    endtask
    // drq after the opcode, busy after the last word, done one edge on
    task set_pwd(input [15:0] ctrl, input [15:0] p, input [15:0] rev);
        i_host_model.issue(8'hF1);
        @(posedge ref_clk) #1;
        check(sts, 8'h48);
        i_host_model.sector(ctrl, p, rev);
        check(sts, 8'h80);
        wait_done(1);
    endtask
    // unlock qualifiers trail the slot load by one edge
    task step;
        @(posedge ref_clk) #1;
    endtask
    task t_power_up;
        power_on(1'b1);
        check(sts, 8'h40);
        check(err, 8'h00);
        check(w92, 16'hFFFE);
        check(lock_en, 1'b0);
    endtask
    // master entry, reserved bits set; bad revision codes are dropped
    task t_master;
        set_pwd(16'hFEFF, 16'h1000, 16'h1234);
        check(w92, 16'h1234);
        check(lock_en, 1'b0);
        power_on(1'b0);
        check(locked, 1'b0);
        for (i = 0; i < 2; i = i + 1) begin
            set_pwd(16'h0101, 16'h2000, i ? 16'hFFFF : 16'h0000);
            check(w92, 16'h1234);
            check(lock_en, 1'b0);
        end
    endtask
    // unimplemented security opcodes, back to back
    task t_reject;
        for (i = 0; i < 4; i = i + 1) begin
            cmd(i == 3 ? 8'hF6 : 8'hF2 + i[7:0]);
            check(sts, 8'h41);
            check(err, 8'h04);
        end
    endtask
    // user and master entries at both levels, then link resets
    task t_user;
        set_pwd(16'h0100, 16'h3000, 16'h5555);
        check(lock_en, 1'b1);
        check(lvl_max, 1'b1);
        check(w92, 16'h1234);
        check(locked, 1'b0);
        step;
        check(user_ok, 1'b1);
        check(master_ok, 1'b0);
        check(erase_only, 1'b0);
        set_pwd(16'h0101, 16'h2000, 16'h0042);
        check(w92, 16'h0042);
        check(lvl_max, 1'b1);
        step;
        check(user_ok, 1'b0);
        check(master_ok, 1'b0);
        check(erase_only, 1'b1);
        set_pwd(16'h7E00, 16'h4000, 16'h6666);
        check(lvl_max, 1'b0);
        check(w92, 16'h0042);
        set_pwd(16'h0001, 16'h2000, 16'h0042);
        step;
        check(master_ok, 1'b1);
        check(user_ok, 1'b0);
        check(erase_only, 1'b0);
        link_reset(1'b0);
        check(locked, 1'b0);
        link_reset(1'b1);
        check(locked, 1'b1);
    endtask
    // freeze, refused set password, survives link reset and re-freeze
    task t_freeze;
        cmd(8'hF5);
        check(frozen, 1'b1);
        check(sts, 8'h40);
        cmd(8'hF1);
        check(sts, 8'h41);
        check(err, 8'h04);
        link_reset(1'b1);
        cmd(8'hF5);
        check(frozen, 1'b1);
        power_on(1'b0);
        check(frozen, 1'b0);
        check(locked, 1'b1);
    endtask
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        nv_clear = 1'b1;
        comreset_pin = 1'b0;
        ssp_disable_pin = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        t_power_up;
        t_master;
        t_reject;
        t_user;
        t_freeze;
        tally_and_finish;
    end
endmodule // drive_security_lock_commands_tb_top
